// File: shared/sge_consts.svh
// Constants for the serial-linked ten-port I/O expander
`ifndef SGE_CONSTS_SVH
`define SGE_CONSTS_SVH

`define SGE_FRAME_BITS     16
`define SGE_NUM_PORTS      10
`define SGE_DIR_BIT        15
`define SGE_ADDR_HI        14
`define SGE_ADDR_LO        8
`define SGE_DATA_HI        7
`define SGE_LEVEL_BIT      0

`define SGE_ADDR_PORT0     7'h00
`define SGE_ADDR_PORT4     7'h04
`define SGE_ADDR_PORT8     7'h08
`define SGE_ADDR_PORT9     7'h09
`define SGE_ADDR_GRP_ALL   7'h0A
`define SGE_ADDR_GRP_LO    7'h0B
`define SGE_ADDR_GRP_MID   7'h0C
`define SGE_ADDR_GRP_HI    7'h0D
`define SGE_ADDR_PIN_LO    7'h0E
`define SGE_ADDR_PIN_HI    7'h0F
`define SGE_ADDR_SCRATCH   7'h13
`define SGE_ADDR_NOOP      7'h20

`define SGE_MASK_NONE      10'h000
`define SGE_MASK_ONE       10'h001
`define SGE_MASK_ALL       10'h3FF
`define SGE_MASK_LO        10'h00F
`define SGE_MASK_MID       10'h0F0
`define SGE_MASK_HI        10'h300

`define SGE_PORT_RESET     8'hFF
`define SGE_SCRATCH_RESET  8'h00
`define SGE_READ_NONE      8'h00
`define SGE_SYNC_STAGES    2

`endif

// File: shared/sge_pkg.sv
// Types shared by the I/O expander design files
`include "sge_consts.svh"

package sge_pkg;

	typedef enum logic {
		SGE_WRITE = 1'b0,
		SGE_READ  = 1'b1
	} sge_dir_t;

	typedef logic [`SGE_NUM_PORTS-1:0][7:0] sge_ctrl_t;

	typedef struct packed {
		logic                       sclkPrev;
		logic                       csNPrev;
		logic [`SGE_FRAME_BITS-1:0] shiftReg;
		sge_ctrl_t                  portCtrl;
		logic [7:0]                 scratch;
		logic                       doutBit;
		logic [`SGE_NUM_PORTS-1:0]  pinOe;
		logic [`SGE_NUM_PORTS-1:0]  pinOut;
		logic                       shutdown;
	} sge_state_t;

endpackage

// File: hw/sge_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`include "sge_consts.svh"

module sge_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sge_sync_state_t;

	sge_sync_state_t st_q;
	sge_sync_state_t st_d;

	if (WIDTH < 1) begin : gWidthCheck
		$error("sge_sync needs at least one bit");
	end

	// Stage one feeds stage two only, nothing else looks at it
	always_comb begin
		st_d        = st_q;
		st_d.stage1 = asyncIn;
		st_d.stage2 = st_q.stage1;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign syncOut = st_q.stage2;

endmodule

// File: hw/sge_expander.sv
// Ten-port I/O expander core behind a four-wire serial link
`timescale 1ns/10ps
`include "sge_consts.svh"

module sge_expander
	import sge_pkg::*;
#(
	parameter int NUM_PORTS = `SGE_NUM_PORTS
) (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 sclk,
	input  wire logic                 csN,
	input  wire logic                 din,
	output logic                      dout,
	input  wire logic [NUM_PORTS-1:0] ioPortPinsIn,
	output logic      [NUM_PORTS-1:0] ioPortPinsOut,
	output logic      [NUM_PORTS-1:0] ioPortPinsOe,
	output logic                      shutdownMode
);

	localparam int SYNC_W = NUM_PORTS + 3;

	if (NUM_PORTS != `SGE_NUM_PORTS) begin : gPortCheck
		$error("sge_expander serves exactly ten ports");
	end

	sge_state_t st_q;
	sge_state_t st_d;

	logic [SYNC_W-1:0]    syncIn;
	logic [SYNC_W-1:0]    syncOut;
	logic                 sclkSync;
	logic                 csNSync;
	logic                 dinSync;
	logic [NUM_PORTS-1:0] pinLevels;
	logic                 csLow;
	logic                 sclkRise;
	logic                 sclkFall;
	logic                 csRise;
	logic [6:0]           cmdAddr;
	logic [7:0]           cmdData;
	sge_dir_t             cmdDir;
	logic [NUM_PORTS-1:0] wrMask;

	// Link clock is slow enough to be oversampled by the core clock
	// Select travels inverted: cleared sync flops then read deselected,
	// so leaving reset never fakes a select rise and a stray commit
	assign syncIn = {sclk, !csN, din, ioPortPinsIn};

	sge_sync #(
		.WIDTH (SYNC_W)
	) uSync (
		.clock   (clock),
		.rst_n   (rst_n),
		.asyncIn (syncIn),
		.syncOut (syncOut)
	);

	assign sclkSync  = syncOut[SYNC_W-1];
	assign csNSync   = !syncOut[SYNC_W-2];
	assign dinSync   = syncOut[SYNC_W-3];
	assign pinLevels = syncOut[NUM_PORTS-1:0];

	// Edges only count while selected, so shared lines stay harmless
	assign csLow    = !csNSync;
	assign sclkRise = csLow && sclkSync && !st_q.sclkPrev;
	assign sclkFall = csLow && !sclkSync && st_q.sclkPrev;
	assign csRise   = csNSync && !st_q.csNPrev;

	// Command byte sits above the data byte
	assign cmdDir  = sge_dir_t'(st_q.shiftReg[`SGE_DIR_BIT]);
	assign cmdAddr = st_q.shiftReg[`SGE_ADDR_HI:`SGE_ADDR_LO];
	assign cmdData = st_q.shiftReg[`SGE_DATA_HI:0];

	// Ports touched by a write to one address
	function automatic logic [NUM_PORTS-1:0] writeMask(
		input logic [6:0] a
	);
		writeMask = `SGE_MASK_NONE;
		if (a <= `SGE_ADDR_PORT9) begin
			writeMask = `SGE_MASK_ONE << a;
		end else if (a == `SGE_ADDR_GRP_ALL) begin
			writeMask = `SGE_MASK_ALL;
		end else if (a == `SGE_ADDR_GRP_LO) begin
			writeMask = `SGE_MASK_LO;
		end else if (a == `SGE_ADDR_GRP_MID) begin
			writeMask = `SGE_MASK_MID;
		end else if (a == `SGE_ADDR_GRP_HI) begin
			writeMask = `SGE_MASK_HI;
		end
	endfunction

	// Byte returned by a read of one address
	function automatic logic [7:0] readValue(
		input logic [6:0]           a,
		input sge_ctrl_t            ctrl,
		input logic [NUM_PORTS-1:0] pins,
		input logic [7:0]           scr
	);
		readValue = `SGE_READ_NONE;
		if (a <= `SGE_ADDR_PORT9) begin
			readValue = ctrl[a[3:0]];
		end else if (a == `SGE_ADDR_GRP_ALL) begin
			readValue = ctrl[`SGE_ADDR_PORT0];
		end else if (a == `SGE_ADDR_GRP_LO) begin
			readValue = ctrl[`SGE_ADDR_PORT0];
		end else if (a == `SGE_ADDR_GRP_MID) begin
			readValue = ctrl[`SGE_ADDR_PORT4];
		end else if (a == `SGE_ADDR_GRP_HI) begin
			readValue = ctrl[`SGE_ADDR_PORT8];
		end else if (a == `SGE_ADDR_PIN_LO) begin
			readValue = pins[7:0];
		end else if (a == `SGE_ADDR_PIN_HI) begin
			readValue = {6'h00, pins[9:8]};
		end else if (a == `SGE_ADDR_SCRATCH) begin
			readValue = scr;
		end
	endfunction

	// Pin-level, dummy_no_operation and unknown addresses yield an empty mask
	assign wrMask = (cmdDir == SGE_WRITE) ? writeMask(cmdAddr)
	                                      : `SGE_MASK_NONE;

	always_comb begin
		st_d          = st_q;
		st_d.sclkPrev = sclkSync;
		st_d.csNPrev  = csNSync;
		st_d.shutdown = st_q.shutdown;
		st_d.pinOut   = `SGE_MASK_NONE;

		if (sclkRise) begin
			st_d.shiftReg = {st_q.shiftReg[`SGE_FRAME_BITS-2:0],
			                 dinSync};
		end

		// Only the falling edge moves data out, giving the half cycle
		if (sclkFall) begin
			st_d.doutBit = st_q.shiftReg[`SGE_FRAME_BITS-1];
		end

		// Longer bursts simply push their early bits out the top
		if (csRise) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (wrMask[p]) begin
					st_d.portCtrl[p] = cmdData;
				end
			end
			if (cmdDir == SGE_WRITE &&
			    cmdAddr == `SGE_ADDR_SCRATCH) begin
				st_d.scratch = cmdData;
			end
			if (cmdDir == SGE_READ) begin
				st_d.shiftReg[`SGE_DATA_HI:0] =
					readValue(cmdAddr, st_q.portCtrl,
					          pinLevels, st_q.scratch);
			end
		end

		// Only the level bit matters; other codes follow it
		for (int p = 0; p < NUM_PORTS; p++) begin
			st_d.pinOe[p] = !st_d.portCtrl[p][`SGE_LEVEL_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_q.sclkPrev <= 1'b0;
			st_q.csNPrev  <= 1'b1;
			st_q.shiftReg <= '0;
			st_q.portCtrl <= {NUM_PORTS{`SGE_PORT_RESET}};
			st_q.scratch  <= `SGE_SCRATCH_RESET;
			st_q.doutBit  <= 1'b0;
			st_q.pinOe    <= `SGE_MASK_NONE;
			st_q.pinOut   <= `SGE_MASK_NONE;
			st_q.shutdown <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// No enable on data out: it is driven even when deselected
	assign dout          = st_q.doutBit;
	assign ioPortPinsOut = st_q.pinOut;
	assign ioPortPinsOe  = st_q.pinOe;
	assign shutdownMode  = st_q.shutdown;

	AST_SHIFT_IN: assert property (@(posedge clock) disable iff (!rst_n)
		sclkRise |=> st_q.shiftReg ==
			{$past(st_q.shiftReg[14:0]), $past(dinSync)})
		else $error("shift register missed a rising edge");

	AST_DOUT_FALL: assert property (@(posedge clock) disable iff (!rst_n)
		sclkFall |=> dout == $past(st_q.shiftReg[15]))
		else $error("data out not updated on falling edge");

	AST_DOUT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
		!sclkFall |=> $stable(dout))
		else $error("data out moved outside a falling edge");

	AST_CS_IGNORE: assert property (@(posedge clock) disable iff (!rst_n)
		(csNSync && !csRise) |=> $stable(st_q.shiftReg))
		else $error("shift register moved while deselected");

	AST_PORT_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
		(csRise && cmdDir == SGE_WRITE && cmdAddr == 7'h05)
		|=> st_q.portCtrl[5] == $past(cmdData))
		else $error("single port write lost");

	AST_GROUP_MID: assert property (@(posedge clock) disable iff (!rst_n)
		(csRise && cmdDir == SGE_WRITE && cmdAddr == `SGE_ADDR_GRP_MID)
		|=> st_q.portCtrl[7:4] == {4{$past(cmdData)}} &&
		    st_q.portCtrl[3:0] == $past(st_q.portCtrl[3:0]))
		else $error("group write to ports four to seven wrong");

	AST_PIN_RO: assert property (@(posedge clock) disable iff (!rst_n)
		(csRise && cmdDir == SGE_WRITE &&
		 (cmdAddr == `SGE_ADDR_PIN_LO || cmdAddr == `SGE_ADDR_PIN_HI))
		|=> $stable(st_q.portCtrl) && $stable(st_q.scratch))
		else $error("write to pin-level address changed state");

	AST_NOOP: assert property (@(posedge clock) disable iff (!rst_n)
		(csRise && cmdAddr == `SGE_ADDR_NOOP)
		|=> $stable(st_q.portCtrl) && $stable(st_q.scratch) &&
		    st_q.shiftReg[7:0] == ($past(cmdDir) == SGE_READ ?
		    8'h00 : $past(st_q.shiftReg[7:0])))
		else $error("dummy_no_operation frame had an effect");

	AST_OE_LEVEL: assert property (@(posedge clock) disable iff (!rst_n)
		ioPortPinsOe[3] == !st_q.portCtrl[3][0] && ioPortPinsOut == '0)
		else $error("port drive does not follow its level bit");

	AST_READ_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
		(csRise && cmdDir == SGE_READ && cmdAddr == `SGE_ADDR_SCRATCH)
		|=> st_q.shiftReg[7:0] == $past(st_q.scratch))
		else $error("read data not loaded for next frame");

	AST_WRITE_ONE: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_WRITE && cmdAddr <= `SGE_ADDR_PORT9)
		|=> st_q.portCtrl[$past(cmdAddr[3:0])] == $past(cmdData))
		else $error("port register write lost");

	AST_GROUP_ALL: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_WRITE && cmdAddr == `SGE_ADDR_GRP_ALL)
		|=> st_q.portCtrl == {`SGE_NUM_PORTS{$past(cmdData)}})
		else $error("group write to all ports wrong");

	AST_GROUP_LO: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_WRITE && cmdAddr == `SGE_ADDR_GRP_LO)
		|=> st_q.portCtrl[3:0] == {4{$past(cmdData)}} &&
		    st_q.portCtrl[9:4] == $past(st_q.portCtrl[9:4]))
		else $error("group write to ports zero to three wrong");

	AST_GROUP_HI: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_WRITE && cmdAddr == `SGE_ADDR_GRP_HI)
		|=> st_q.portCtrl[9:8] == {2{$past(cmdData)}} &&
		    st_q.portCtrl[7:0] == $past(st_q.portCtrl[7:0]))
		else $error("group write to ports eight and nine wrong");

	AST_SCRATCH_WR: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_WRITE && cmdAddr == `SGE_ADDR_SCRATCH)
		|=> st_q.scratch == $past(cmdData) && $stable(st_q.portCtrl))
		else $error("scratch write lost or leaked to ports");

	AST_UNDEF_WR: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_WRITE &&
		 cmdAddr > `SGE_ADDR_PIN_HI && cmdAddr != `SGE_ADDR_SCRATCH)
		|=> $stable(st_q.portCtrl) && $stable(st_q.scratch))
		else $error("write to an undefined address changed state");

	AST_READ_SAFE: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_READ)
		|=> $stable(st_q.portCtrl) && $stable(st_q.scratch) &&
		    st_q.shiftReg[15:8] == $past(st_q.shiftReg[15:8]))
		else $error("read frame changed a register");

	AST_NO_COMMIT: assert property (@(posedge clock)
		disable iff (!rst_n)
		!csRise |=> $stable(st_q.portCtrl) && $stable(st_q.scratch))
		else $error("registers changed without a select rise");

	AST_PINS_LO: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_READ && cmdAddr == `SGE_ADDR_PIN_LO)
		|=> st_q.shiftReg[7:0] == $past(pinLevels[7:0]))
		else $error("low pin levels not returned");

	AST_PINS_HI: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_READ && cmdAddr == `SGE_ADDR_PIN_HI)
		|=> st_q.shiftReg[7:0] == {6'h00, $past(pinLevels[9:8])})
		else $error("high pin levels not returned");

	AST_READ_GRP: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_READ && cmdAddr == `SGE_ADDR_GRP_MID)
		|=> st_q.shiftReg[7:0] == $past(st_q.portCtrl[4]))
		else $error("group read did not return its first port");

	AST_UNDEF_RD: assert property (@(posedge clock)
		disable iff (!rst_n)
		(csRise && cmdDir == SGE_READ && cmdAddr > `SGE_ADDR_SCRATCH)
		|=> st_q.shiftReg[7:0] == `SGE_READ_NONE)
		else $error("read of an undefined address not zero");

	AST_DESELECT: assert property (@(posedge clock)
		disable iff (!rst_n)
		csNSync |=> $stable(dout))
		else $error("data out moved while deselected");

	AST_OE_ENDS: assert property (@(posedge clock)
		disable iff (!rst_n)
		ioPortPinsOe[9] == !st_q.portCtrl[9][0] &&
		ioPortPinsOe[0] == !st_q.portCtrl[0][0])
		else $error("end port drive does not follow its level bit");

	AST_RESET_VAL: assert property (@(posedge clock)
		disable iff (!rst_n)
		!$past(rst_n) |-> shutdownMode &&
		    ioPortPinsOe == `SGE_MASK_NONE &&
		    st_q.portCtrl == {`SGE_NUM_PORTS{`SGE_PORT_RESET}} &&
		    st_q.scratch == `SGE_SCRATCH_RESET)
		else $error("state wrong right after reset release");

endmodule

// File: testbench/sge_host_model.sv
// Host model driving the four-wire serial link
`timescale 1ns/10ps

module sge_host_model (
	input  wire logic clock,
	input  wire logic dout,
	output logic      sclk,
	output logic      csN,
	output logic      din
);
	initial begin
		sclk = 1'b0;
		csN  = 1'b1;
		din  = 1'b0;
	end

	// MSB first; din moves only after sclk falls
	task automatic xfer(input logic [31:0] tx, input int n,
		output logic [15:0] rx);
		rx = 16'h0000;
		csN <= 1'b0;
		din <= tx[n-1];
		repeat (4) @(posedge clock);
		for (int i = n - 1; i >= 0; i--) begin
			sclk <= 1'b1;
			repeat (4) @(posedge clock);
			// Sampled late in the high phase, well after dout settles
			if (n - 1 - i < 16)
				rx[15 - (n - 1 - i)] = dout;
			sclk <= 1'b0;
			if (i > 0)
				din <= tx[i-1];
			repeat (4) @(posedge clock);
		end
		csN <= 1'b1;
		// Released data line must not hold the last bit
		din <= ~din;
		repeat (8) @(posedge clock);
	endtask

	// Shared-bus traffic for some other peripheral
	task automatic noise(input logic [15:0] pat);
		for (int i = 0; i < 16; i++) begin
			sclk <= pat[i];
			din  <= pat[15-i];
			repeat (4) @(posedge clock);
		end
		sclk <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
endmodule

// File: testbench/spi_gpio_expander_10port_test.sv
// Self-checking bench for the ten-port serial I/O expander
`timescale 1ns/10ps
`include "sge_consts.svh"

module spi_gpio_expander_10port_test;
	logic        clock, rst_n, sclk, csN, din, dout, shutdownMode;
	logic [9:0]  pinsIn, pinsOut, pinsOe, ext;
	logic [7:0]  mPort [10];
	logic [7:0]  mScr;
	logic [15:0] prevWord, rx;
	int          mismatches, tests_run, cycles, seed;
	localparam logic [6:0] ADDRS [19] = '{7'h00, 7'h01, 7'h02, 7'h03,
		7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C,
		7'h0D, 7'h0E, 7'h0F, 7'h13, 7'h20, 7'h15};

	// Pins driven low read low; floating pins show the outside level
	assign pinsIn = ext & ~pinsOe;

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	sge_expander u_dut (.clock(clock), .rst_n(rst_n), .sclk(sclk),
		.csN(csN), .din(din), .dout(dout), .ioPortPinsIn(pinsIn),
		.ioPortPinsOut(pinsOut), .ioPortPinsOe(pinsOe),
		.shutdownMode(shutdownMode));
	sge_host_model u_host (.clock(clock), .dout(dout), .sclk(sclk),
		.csN(csN), .din(din));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic cmpWord(string nm, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (e !== g) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [9:0] expOe();
		logic [9:0] v;
		for (int p = 0; p < 10; p++)
			v[p] = ~mPort[p][0];
		return v;
	endfunction

	function automatic logic [7:0] expRead(logic [6:0] a);
		if (a <= `SGE_ADDR_PORT9)
			return mPort[a[3:0]];
		case (a)
			`SGE_ADDR_GRP_ALL, `SGE_ADDR_GRP_LO: return mPort[0];
			`SGE_ADDR_GRP_MID: return mPort[4];
			`SGE_ADDR_GRP_HI:  return mPort[8];
			`SGE_ADDR_PIN_LO:  return pinsIn[7:0];
			`SGE_ADDR_PIN_HI:  return {6'h00, pinsIn[9:8]};
			`SGE_ADDR_SCRATCH: return mScr;
			default:           return 8'h00;
		endcase
	endfunction

	task automatic modelWrite(logic [6:0] a, logic [7:0] d);
		int lo, hi;
		lo = 1;
		hi = 0;
		if (a <= `SGE_ADDR_PORT9) begin
			lo = a;
			hi = a;
		end
		case (a)
			`SGE_ADDR_GRP_ALL: begin lo = 0; hi = 9; end
			`SGE_ADDR_GRP_LO:  begin lo = 0; hi = 3; end
			`SGE_ADDR_GRP_MID: begin lo = 4; hi = 7; end
			`SGE_ADDR_GRP_HI:  begin lo = 8; hi = 9; end
			default: ;
		endcase
		for (int p = lo; p <= hi; p++)
			mPort[p] = d;
		if (a == `SGE_ADDR_SCRATCH)
			mScr = d;
	endtask

	// One frame; the reply must be the previous frame's word, with the read data as its low byte after a read
	task automatic acc(logic rd, logic [6:0] a, logic [7:0] d, int n);
		logic [15:0] w;
		w = {rd, a, d};
		u_host.xfer({16'($random(seed)), w}, n, rx);
		cmpWord("shifted out", prevWord, rx);
		if (rd) begin
			prevWord = {w[15:8], expRead(a)};
		end else begin
			modelWrite(a, d);
			prevWord = w;
		end
		cmpWord("drive enables", {6'h00, expOe()}, {6'h00, pinsOe});
	endtask

	task automatic doReset();
		rst_n <= 1'b0;
		repeat (8) @(posedge clock);
		for (int p = 0; p < 10; p++)
			mPort[p] = `SGE_PORT_RESET;
		mScr = `SGE_SCRATCH_RESET;
		prevWord = 16'h0000;
		cmpWord("drive enables", 16'h0000, {6'h00, pinsOe});
		cmpWord("pin drive", 16'h0000, {6'h00, pinsOut});
		cmpWord("shutdown", 16'h0001, {15'h0000, shutdownMode});
		cmpWord("dout", 16'h0000, {15'h0000, dout});
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		foreach (ADDRS[i])
			acc(1'b1, ADDRS[i], 8'h00, 16);
		$display("test reset done");
	endtask

	initial begin
		seed = 81;
		rst_n = 1'b0;
		ext = 10'h3FF;
		doReset();
		for (int a = 10; a <= 13; a++) begin
			acc(1'b0, 7'(a), 8'h00, 16);
			acc(1'b1, 7'(a), 8'h00, 16);
			acc(1'b0, 7'(a), 8'h01, 16);
		end
		$display("test groups done");
		repeat (80) begin
			@(posedge clock);
			ext <= 10'($random(seed));
			acc(1'($random(seed)), ADDRS[$unsigned($random(seed)) % 19],
				8'($random(seed)), 16);
		end
		$display("test random done");
		u_host.noise(16'($random(seed)));
		acc(1'b0, `SGE_ADDR_SCRATCH, 8'($random(seed)), 24);
		acc(1'b1, `SGE_ADDR_SCRATCH, 8'h00, 16);
		acc(1'b1, `SGE_ADDR_NOOP, 8'h00, 16);
		acc(1'b0, 7'h05, 8'h00, 16);
		acc(1'b0, `SGE_ADDR_PIN_HI, 8'h00, 16);
		acc(1'b0, 7'h15, 8'h00, 16);
		acc(1'b1, 7'h05, 8'h00, 16);
		$display("test burst done");
		doReset();
		wrap_up();
	end
endmodule
